// ==== design/iqc_pkg.sv ====
// package of constants and carrier types for the iq converter port controller
package iqc_pkg;
	localparam int CLK_PERIOD_NS   = 100;     // period of the 10 mhz clock
	localparam int TX_DATA_W       = 10;      // transmit sample width
	localparam int RX_DATA_W       = 8;       // receive sample width
	localparam int PWR_WAIT_US     = 100;     // power-up settling wait
	localparam int LOAD_PULSE_NS   = 100;     // latch load pulse width
	localparam int LOAD_SETUP_NS   = 50;      // load to transfer setup
	localparam int TXS_PULSE_NS    = 100;     // transfer strobe width
	localparam int TXS_PERIOD_NS   = 400;     // transfer strobe period
	localparam int RXS_HIGH_NS     = 200;     // receive strobe high time
	localparam int RXS_LOW_NS      = 200;     // receive strobe low time
	localparam int RXS_PERIOD_NS   = 460;     // receive strobe period
	localparam int RX_DATA_MAX_NS  = 220;     // data valid after period
	localparam int FIFO_DEPTH      = 16;      // transmit fifo depth
	// cycle counts, least times rounded up
	localparam int PWR_WAIT_CYC  = (PWR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_CYC      = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC     = (LOAD_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TXS_CYC       = (TXS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TXS_PER_CYC   = (TXS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RXS_HIGH_CYC  = (RXS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RXS_LOW_RAW   = (RXS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RXS_PER_CYC   = (RXS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RXS_LOW_CYC   = (RXS_PER_CYC - RXS_HIGH_CYC > RXS_LOW_RAW) ?
		(RXS_PER_CYC - RXS_HIGH_CYC) : RXS_LOW_RAW;
	// data is sampled RX_VALID_CYC plus one cycles into each low phase after the first; RX_VALID_CYC is the 220 ns delay rounded up
	localparam int RX_VALID_CYC  = (RX_DATA_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// transmit sample pair carried through the fifo
	typedef struct packed {
		logic [TX_DATA_W-1:0] inphase;     // in-phase code
		logic [TX_DATA_W-1:0] quadrature;  // quadrature code
	} iqc_pair_t;
	localparam int PAIR_W = 2 * TX_DATA_W;  // width of one pair
	// receive sample with its valid flag
	typedef struct packed {
		logic                 valid;       // sample present
		logic [RX_DATA_W-1:0] data;        // sample code
	} iqc_rx_t;
endpackage : iqc_pkg

// ==== design/iqc_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module iqc_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];   // storage array
	logic [AW-1:0]    wr_ptr_q;        // write index
	logic [AW-1:0]    rd_ptr_q;        // read index
	logic [AW:0]      count_q;         // words held
	logic             push;            // write accepted
	logic             pop;             // read accepted
	// honest flags from the fill count
	assign wr_ready_out = (count_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign rd_valid_out = (count_q != '0);
	assign rd_data_out  = mem_q[rd_ptr_q];
	assign push = wr_valid_in && wr_ready_out;
	assign pop  = rd_valid_out && rd_ready_in;
	// storage write, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr_data_in;
		end
	end
	// pointers and count
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : iqc_fifo

// ==== design/iqc_host.sv ====
// host controller driving the iq converter parallel port pins
//
// Function
// (RULE_01) device latches in-phase and quadrature from bus
// (RULE_02) device outputs change only on transfer
// (RULE_03) transfer strobe updates both channels together
// (RULE_04) load both latches before each transfer
// (RULE_05) device tx outputs float while powered down
// (RULE_06) device resets tx codes to mid-scale
// (RULE_07) wait 100 us after tx power-up
// (RULE_08) transfer strobe 100 ns wide, 400 ns apart
// (RULE_09) wait 100 us after rx power-up
// (RULE_10) rx strobe period 460, phases 200 ns
// (RULE_11) device data valid period plus 220 ns
// (RULE_12) device floats rx bus within 40 ns
// (RULE_13) conversion result appears at next rising edge
// (RULE_14) time all waits with rounded-up counters
`timescale 1ns/1ns
module iqc_host
	import iqc_pkg::*;
#(
	parameter int PWR_WAIT = PWR_WAIT_CYC   // power-up wait in cycles
) (
	input  wire logic                 MCLK_IN,
	input  wire logic                 RESET_N_IN,
	input  wire logic                 TX_ENABLE_IN,
	input  wire logic [PAIR_W-1:0]    TX_PAIR_IN,
	input  wire logic                 TX_VALID_IN,
	output logic                      TX_READY_OUT,
	input  wire logic                 RX_ENABLE_IN,
	input  wire logic [RX_DATA_W-1:0] RX_SAMPLE_BUS_IN,
	output logic                      TX_POWER_UP_OUT,
	output logic                      RX_POWER_UP_OUT,
	output logic [TX_DATA_W-1:0]      TX_SAMPLE_BUS_OUT,
	output logic                      INPHASE_LATCH_LOAD_OUT,
	output logic                      QUADRATURE_LATCH_LOAD_OUT,
	output logic                      TX_TRANSFER_OUT,
	output logic                      RX_STROBE_OUT,
	output logic [RX_DATA_W-1:0]      RX_DATA_OUT,
	output logic                      RX_VALID_OUT,
	output logic                      TX_READY_STATE_OUT,
	output logic                      RX_READY_STATE_OUT
);
	typedef enum logic [2:0] {
		TX_OFF, TX_WAIT, TX_IDLE, TX_LOAD_I, TX_LOAD_Q, TX_SETUP, TX_STROBE, TX_GAP
	} iqc_tx_state_t;
	typedef enum logic [1:0] {RX_OFF, RX_WAIT, RX_HIGH, RX_LOW} iqc_rx_state_t;

	localparam int CW = $clog2(PWR_WAIT + 1) + 1;  // counter width
	iqc_tx_state_t tx_state_q;          // transmit sequencer
	iqc_rx_state_t rx_state_q;          // receive strobe sequencer
	logic [CW-1:0] tx_cnt_q;            // transmit phase counter
	logic [CW-1:0] rx_cnt_q;            // receive phase counter
	logic [1:0]    tx_en_sync_q;        // tx enable synchroniser
	logic [1:0]    rx_en_sync_q;        // rx enable synchroniser
	logic [RX_DATA_W-1:0] rx_bus_s1_q;  // rx bus first stage
	logic [RX_DATA_W-1:0] rx_bus_s2_q;  // rx bus second stage
	logic          rx_armed_q;          // a conversion is pending
	iqc_pair_t     pair;                // fifo head
	logic          pair_valid;          // fifo has a pair
	logic          pair_take;           // pop pulse
	logic          tx_ready_w;          // fifo ready

	// transmit sample buffer; back-pressure reaches the source
	iqc_fifo #(.WIDTH(PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in       (MCLK_IN),
		.reset_n_in   (RESET_N_IN),
		.wr_data_in   (TX_PAIR_IN),
		.wr_valid_in  (TX_VALID_IN),
		.wr_ready_out (tx_ready_w),
		.rd_data_out  (pair),
		.rd_valid_out (pair_valid),
		.rd_ready_in  (pair_take)
	);
	// pair leaves the fifo when the transfer strobe fires; a power-down in that
	// same cycle aborts the transfer, so the pair must stay queued for later
	assign pair_take = (tx_state_q == TX_SETUP) && (tx_cnt_q == CW'(SETUP_CYC - 1)) &&
		tx_en_sync_q[1];

	// two-stage synchronisers for asynchronous inputs
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			tx_en_sync_q <= '0;
			rx_en_sync_q <= '0;
			rx_bus_s1_q  <= '0;
			rx_bus_s2_q  <= '0;
		end else begin
			tx_en_sync_q <= {tx_en_sync_q[0], TX_ENABLE_IN};
			rx_en_sync_q <= {rx_en_sync_q[0], RX_ENABLE_IN};
			rx_bus_s1_q  <= RX_SAMPLE_BUS_IN;
			rx_bus_s2_q  <= rx_bus_s1_q;
		end
	end

	// fifo ready registered copy for the top output
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			TX_READY_OUT <= 1'b0;
		end else begin
			TX_READY_OUT <= tx_ready_w;
		end
	end

	// transmit sequencer: power-up, load i, load q, transfer
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			tx_state_q                <= TX_OFF;
			tx_cnt_q                  <= '0;
			TX_POWER_UP_OUT           <= 1'b0;
			TX_SAMPLE_BUS_OUT         <= '0;
			INPHASE_LATCH_LOAD_OUT    <= 1'b0;
			QUADRATURE_LATCH_LOAD_OUT <= 1'b0;
			TX_TRANSFER_OUT           <= 1'b0;
			TX_READY_STATE_OUT        <= 1'b0;
		end else if (!tx_en_sync_q[1]) begin
			// power down; device outputs float and codes reset on next rise
			tx_state_q                <= TX_OFF; // RULE_05
			tx_cnt_q                  <= '0;
			TX_POWER_UP_OUT           <= 1'b0;
			INPHASE_LATCH_LOAD_OUT    <= 1'b0;
			QUADRATURE_LATCH_LOAD_OUT <= 1'b0;
			TX_TRANSFER_OUT           <= 1'b0;
			TX_READY_STATE_OUT        <= 1'b0;
		end else begin
			case (tx_state_q)
				TX_OFF: begin
					TX_POWER_UP_OUT <= 1'b1; // RULE_06
					tx_cnt_q        <= '0;
					tx_state_q      <= TX_WAIT;
				end
				TX_WAIT: begin
					// settle before any latch load or transfer
					if (tx_cnt_q == CW'(PWR_WAIT - 1)) begin // RULE_07 RULE_14
						tx_cnt_q           <= '0;
						tx_state_q         <= TX_IDLE;
						TX_READY_STATE_OUT <= 1'b1;
					end else begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
					end
				end
				TX_IDLE: begin
					if (pair_valid) begin
						TX_SAMPLE_BUS_OUT      <= pair.inphase; // RULE_01
						INPHASE_LATCH_LOAD_OUT <= 1'b1;
						tx_cnt_q               <= '0;
						tx_state_q             <= TX_LOAD_I;
					end
				end
				TX_LOAD_I: begin
					// data stable while the load pulse is high
					if (tx_cnt_q == CW'(LOAD_CYC - 1)) begin
						INPHASE_LATCH_LOAD_OUT <= 1'b0;
						tx_cnt_q               <= '0;
						tx_state_q             <= TX_LOAD_Q;
					end else begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
					end
				end
				TX_LOAD_Q: begin
					// bus changes one cycle after the falling load edge
					if (!QUADRATURE_LATCH_LOAD_OUT && tx_cnt_q == '0) begin
						TX_SAMPLE_BUS_OUT         <= pair.quadrature; // RULE_04
						QUADRATURE_LATCH_LOAD_OUT <= 1'b1;
					end else if (tx_cnt_q == CW'(LOAD_CYC - 1)) begin
						QUADRATURE_LATCH_LOAD_OUT <= 1'b0;
						tx_cnt_q                  <= '0;
						tx_state_q                <= TX_SETUP;
					end else begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
					end
				end
				TX_SETUP: begin
					// both latches hold the pair; now transfer together
					if (tx_cnt_q == CW'(SETUP_CYC - 1)) begin
						TX_TRANSFER_OUT <= 1'b1; // RULE_03 RULE_02
						tx_cnt_q        <= '0;
						tx_state_q      <= TX_STROBE;
					end else begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
					end
				end
				TX_STROBE: begin
					if (tx_cnt_q == CW'(TXS_CYC - 1)) begin // RULE_08
						TX_TRANSFER_OUT <= 1'b0;
						tx_state_q      <= TX_GAP;
					end
					tx_cnt_q <= tx_cnt_q + 1'b1;
				end
				TX_GAP: begin
					// hold off until the strobe period has elapsed
					if (tx_cnt_q >= CW'(TXS_PER_CYC - 1)) begin // RULE_08
						tx_cnt_q   <= '0;
						tx_state_q <= TX_IDLE;
					end else begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
					end
				end
				default: begin
					tx_state_q <= TX_OFF;
				end
			endcase
		end
	end

	// receive strobe generator and sample capture
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rx_state_q         <= RX_OFF;
			rx_cnt_q           <= '0;
			rx_armed_q         <= 1'b0;
			RX_POWER_UP_OUT    <= 1'b0;
			RX_STROBE_OUT      <= 1'b0;
			RX_DATA_OUT        <= '0;
			RX_VALID_OUT       <= 1'b0;
			RX_READY_STATE_OUT <= 1'b0;
		end else if (!rx_en_sync_q[1]) begin
			// power down; device floats its bus, nothing captured
			rx_state_q         <= RX_OFF; // RULE_12
			rx_cnt_q           <= '0;
			rx_armed_q         <= 1'b0;
			RX_POWER_UP_OUT    <= 1'b0;
			RX_STROBE_OUT      <= 1'b0;
			RX_VALID_OUT       <= 1'b0;
			RX_READY_STATE_OUT <= 1'b0;
		end else begin
			RX_VALID_OUT <= 1'b0;
			case (rx_state_q)
				RX_OFF: begin
					RX_POWER_UP_OUT <= 1'b1;
					rx_cnt_q        <= '0;
					rx_state_q      <= RX_WAIT;
				end
				RX_WAIT: begin
					if (rx_cnt_q == CW'(PWR_WAIT - 1)) begin // RULE_09 RULE_14
						rx_cnt_q           <= '0;
						RX_STROBE_OUT      <= 1'b1;
						RX_READY_STATE_OUT <= 1'b1;
						rx_state_q         <= RX_HIGH;
					end else begin
						rx_cnt_q <= rx_cnt_q + 1'b1;
					end
				end
				RX_HIGH: begin
					if (rx_cnt_q == CW'(RXS_HIGH_CYC - 1)) begin // RULE_10
						RX_STROBE_OUT <= 1'b0;
						rx_cnt_q      <= '0;
						rx_state_q    <= RX_LOW;
					end else begin
						rx_cnt_q <= rx_cnt_q + 1'b1;
					end
				end
				RX_LOW: begin
					// previous conversion settled: period plus max delay passed
					if (rx_cnt_q == CW'(RX_VALID_CYC + 1) && rx_armed_q) begin // RULE_11 RULE_13
						RX_DATA_OUT  <= rx_bus_s2_q;
						RX_VALID_OUT <= 1'b1;
					end
					if (rx_cnt_q >= CW'(RXS_LOW_CYC - 1) &&
						rx_cnt_q >= CW'(RX_VALID_CYC + 1)) begin // RULE_10
						RX_STROBE_OUT <= 1'b1;
						rx_armed_q    <= 1'b1;
						rx_cnt_q      <= '0;
						rx_state_q    <= RX_HIGH;
					end else begin
						rx_cnt_q <= rx_cnt_q + 1'b1;
					end
				end
				default: begin
					rx_state_q <= RX_OFF;
				end
			endcase
		end
	end
endmodule : iqc_host

// ==== dv/iqc_host_monitor.sv ====
// checker of the controller pin timing
`timescale 1ns/1ns
module iqc_host_monitor
	import iqc_pkg::*;
#(
	parameter int PWR_WAIT = PWR_WAIT_CYC   // power-up wait in cycles
) (
	input wire logic MCLK_IN,
	input wire logic RESET_N_IN,
	input wire logic TX_POWER_UP_OUT,
	input wire logic RX_POWER_UP_OUT,
	input wire logic INPHASE_LATCH_LOAD_OUT,
	input wire logic QUADRATURE_LATCH_LOAD_OUT,
	input wire logic TX_TRANSFER_OUT,
	input wire logic RX_STROBE_OUT,
	input wire logic RX_VALID_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	logic [15:0] tx_on_q;   // cycles with tx powered
	logic [15:0] rx_on_q;   // cycles with rx powered
	// saturating count of powered cycles, tx
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) tx_on_q <= '0;
		else if (!TX_POWER_UP_OUT) tx_on_q <= '0;
		else if (tx_on_q != 16'hffff) tx_on_q <= tx_on_q + 16'h0001;
	end
	// saturating count of powered cycles, rx
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) rx_on_q <= '0;
		else if (!RX_POWER_UP_OUT) rx_on_q <= '0;
		else if (rx_on_q != 16'hffff) rx_on_q <= rx_on_q + 16'h0001;
	end
	property p_tx_wait;
		(INPHASE_LATCH_LOAD_OUT || TX_TRANSFER_OUT) |-> int'(tx_on_q) >= PWR_WAIT;
	endproperty
	a_tx_wait: assert property (p_tx_wait) else $error("tx strobe before wait");
	property p_rx_wait;
		$rose(RX_STROBE_OUT) |-> int'(rx_on_q) >= PWR_WAIT;
	endproperty
	a_rx_wait: assert property (p_rx_wait) else $error("rx strobe before wait");
	property p_q_after_i;
		$rose(QUADRATURE_LATCH_LOAD_OUT) |-> $past(INPHASE_LATCH_LOAD_OUT, 2);
	endproperty
	a_q_after_i: assert property (p_q_after_i) else $error("q load without i");
	property p_xfer_after_q;
		$rose(TX_TRANSFER_OUT) |-> $past(QUADRATURE_LATCH_LOAD_OUT, 2);
	endproperty
	a_xfer_after_q: assert property (p_xfer_after_q) else $error("transfer without q");
	property p_xfer_gap;
		$rose(TX_TRANSFER_OUT) |=> (!$rose(TX_TRANSFER_OUT)) [*3];
	endproperty
	a_xfer_gap: assert property (p_xfer_gap) else $error("transfers too close");
	property p_rxs_high;
		$rose(RX_STROBE_OUT) |=> RX_STROBE_OUT || !RX_POWER_UP_OUT;
	endproperty
	a_rxs_high: assert property (p_rxs_high) else $error("rx strobe high short");
	property p_rxs_low;
		$fell(RX_STROBE_OUT) |=> !RX_STROBE_OUT;
	endproperty
	a_rxs_low: assert property (p_rxs_low) else $error("rx strobe low short");
	property p_rxs_period;
		$rose(RX_STROBE_OUT) |=> (!$rose(RX_STROBE_OUT)) [*4];
	endproperty
	a_rxs_period: assert property (p_rxs_period) else $error("rx period short");
	property p_valid_on;
		RX_VALID_OUT |-> RX_POWER_UP_OUT && $past(RX_POWER_UP_OUT, 7);
	endproperty
	a_valid_on: assert property (p_valid_on) else $error("sample while asleep");
	c_xfer: cover property ($rose(TX_TRANSFER_OUT));
	c_valid: cover property (RX_VALID_OUT);
	c_tx_off: cover property ($fell(TX_POWER_UP_OUT));
endmodule : iqc_host_monitor
bind iqc_host iqc_host_monitor #(.PWR_WAIT(PWR_WAIT)) iqc_host_monitor_i (.MCLK_IN(MCLK_IN),
	.RESET_N_IN(RESET_N_IN), .TX_POWER_UP_OUT(TX_POWER_UP_OUT), .RX_POWER_UP_OUT(RX_POWER_UP_OUT),
	.INPHASE_LATCH_LOAD_OUT(INPHASE_LATCH_LOAD_OUT), .RX_VALID_OUT(RX_VALID_OUT),
	.QUADRATURE_LATCH_LOAD_OUT(QUADRATURE_LATCH_LOAD_OUT),
	.TX_TRANSFER_OUT(TX_TRANSFER_OUT), .RX_STROBE_OUT(RX_STROBE_OUT));

// ==== dv/iqc_device_model.sv ====
// behavioural model of the converter port
`timescale 1ns/1ns
module iqc_device_model
	import iqc_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 tx_pwr_in,
	input  wire logic                 rx_pwr_in,
	input  wire logic [TX_DATA_W-1:0] bus_in,
	input  wire logic                 iload_in,
	input  wire logic                 qload_in,
	input  wire logic                 xfer_in,
	input  wire logic                 rxs_in,
	output logic      [RX_DATA_W-1:0] rx_bus_out,
	output logic      [TX_DATA_W-1:0] i_code_out,
	output logic      [TX_DATA_W-1:0] q_code_out,
	output logic                      tx_float_out
);
	logic [TX_DATA_W-1:0] i_lat;   // in-phase input latch
	logic [TX_DATA_W-1:0] q_lat;   // quadrature input latch
	logic [RX_DATA_W-1:0] conv;    // conversion in flight
	logic [RX_DATA_W-1:0] nxt;     // next conversion code
	initial rx_bus_out = 8'h00;
	// latches take the bus once the edge's updates have landed
	always @(posedge iload_in) #1 i_lat = bus_in;
	always @(posedge qload_in) #1 q_lat = bus_in;
	// converter codes move on transfer, both at once, and on tx power-up
	always @(posedge xfer_in) begin
		i_code_out = i_lat;
		q_code_out = q_lat;
	end
	// waking the path sets both codes to mid-scale
	always @(posedge tx_pwr_in) begin
		i_code_out = 10'h200;
		q_code_out = 10'h200;
	end
	assign tx_float_out = !tx_pwr_in;
	// waking the receive path restarts the conversion sequence
	always @(posedge rx_pwr_in) begin
		conv = 8'hbf;
		nxt = 8'h40;
	end
	// each rise shows the last conversion and starts another
	always @(posedge rxs_in) if (rx_pwr_in) begin
		rx_bus_out = conv;
		conv = nxt;
		nxt = nxt + 8'h01;
	end
	// released bus shows a pattern changing every cycle
	always @(posedge clk_in or negedge rx_pwr_in) if (!rx_pwr_in) rx_bus_out <= ~rx_bus_out;
endmodule : iqc_device_model

// ==== dv/tb_iqc_host.sv ====
// self-checking bench for the iq converter port controller
`timescale 1ns/1ns
module tb_iqc_host;
	import iqc_pkg::*;
	logic              clk = 1'b0;      // 10 mhz clock
	logic              rst_n = 1'b0;    // reset, active low
	logic              tx_en = 1'b0;    // tx path enable
	logic              rx_en = 1'b0;    // rx path enable
	logic              valid = 1'b0;    // pair push
	iqc_pair_t         pair = '0;       // pair pushed
	logic [RX_DATA_W-1:0] rx_bus, rx_data;
	logic [TX_DATA_W-1:0] tx_bus, i_code, q_code;
	logic rdy, tx_pwr, rx_pwr, iload, qload, xfer, rxs, rx_valid, tx_rs, rx_rs, tx_float;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	localparam int SIM_WAIT = 10;       // short power-up wait used in simulation
	time t_xfer = 0;                    // time of the last transfer rise
	time t_pwr = 0;                     // time of the last tx power rise
	time t_rxp = 0;                     // time of the last rx power rise
	iqc_pair_t exp_q[$];                // pairs awaiting transfer
	iqc_pair_t prev;                    // codes now on the converters
	iqc_host #(.PWR_WAIT(SIM_WAIT)) iqc_host_i (.MCLK_IN(clk), .RESET_N_IN(rst_n),
		.TX_ENABLE_IN(tx_en), .TX_PAIR_IN(pair), .TX_VALID_IN(valid), .TX_READY_OUT(rdy),
		.RX_ENABLE_IN(rx_en), .RX_SAMPLE_BUS_IN(rx_bus), .TX_POWER_UP_OUT(tx_pwr),
		.RX_POWER_UP_OUT(rx_pwr), .TX_SAMPLE_BUS_OUT(tx_bus), .INPHASE_LATCH_LOAD_OUT(iload),
		.QUADRATURE_LATCH_LOAD_OUT(qload), .TX_TRANSFER_OUT(xfer), .RX_STROBE_OUT(rxs),
		.RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid), .TX_READY_STATE_OUT(tx_rs),
		.RX_READY_STATE_OUT(rx_rs));
	iqc_device_model iqc_device_model_i (.clk_in(clk), .tx_pwr_in(tx_pwr), .rx_pwr_in(rx_pwr),
		.bus_in(tx_bus), .iload_in(iload), .qload_in(qload), .xfer_in(xfer), .rxs_in(rxs),
		.rx_bus_out(rx_bus), .i_code_out(i_code), .q_code_out(q_code), .tx_float_out(tx_float));
	always #50 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// power rise times for the settling checks
	always @(posedge tx_pwr) t_pwr = $time;
	always @(posedge rx_pwr) t_rxp = $time;
	task tick;
		@(posedge clk);
		#1;
	endtask : tick
	task chk(input bit ok, input string msg);
		checks++;
		if (!ok) begin
			miscompares++;
			$display("Error %0t %s", $time, msg);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// push one pair, then let the late ready flag settle
	task push(input iqc_pair_t p);
		pair = p;
		valid = 1'b1;
		tick();
		valid = 1'b0;
		exp_q.push_back(p);
		tick();
	endtask : push
	// watch queued pairs reach the converters in order
	task drain;
		while (exp_q.size() > 0) begin
			@(posedge qload);
			#2 chk({i_code, q_code} === prev, "codes moved on load");
			chk($time - t_pwr >= SIM_WAIT * CLK_PERIOD_NS, "load before wait");
			@(posedge xfer);
			chk($time - t_xfer >= TXS_PERIOD_NS, "transfers too close");
			t_xfer = $time;
			#1 chk({i_code, q_code} === exp_q[0], "codes after transfer");
			prev = exp_q.pop_front();
		end
	endtask : drain
	// fill the buffer while asleep, then drain it
	task t_fill_drain;
		int n;
		n = 0;
		repeat (20) if (rdy === 1'b1) begin
			push({10'(n * 37 + 1), 10'(1023 - n)});
			n++;
		end else tick();
		chk(n >= 15 && n <= 16 && rdy === 1'b0, "buffer did not refuse");
		tx_en = 1'b1;
		while (tx_rs !== 1'b1) tick();
		chk(i_code === 10'h200 && q_code === 10'h200, "not mid-scale");
		prev = {10'h200, 10'h200};
		drain();
		repeat (6) tick();
		chk(rdy === 1'b1, "ready after drain");
	endtask : t_fill_drain
	// sleep, queue a pair, wake, expect mid-scale then the pair
	task t_repower;
		tx_en = 1'b0;
		repeat (5) tick();
		chk(tx_pwr === 1'b0 && tx_float === 1'b1 && tx_rs === 1'b0, "tx still awake");
		push({10'h3ff, 10'h000});
		repeat (4) tick();
		chk(xfer === 1'b0 && iload === 1'b0, "strobe while asleep");
		tx_en = 1'b1;
		while (tx_rs !== 1'b1) tick();
		chk(i_code === 10'h200 && q_code === 10'h200, "no mid-scale");
		prev = {10'h200, 10'h200};
		drain();
	endtask : t_repower
	// receive samples follow the conversion sequence
	task t_rx;
		bit seen;
		rx_en = 1'b1;
		@(posedge rxs);
		chk($time - t_rxp >= SIM_WAIT * CLK_PERIOD_NS, "rx strobe early");
		for (int k = 0; k < 4; k++) begin
			tick();
			while (rx_valid !== 1'b1) tick();
			chk(rx_data === 8'(8'h40 + k), "rx sample");
		end
		chk(rx_rs === 1'b1, "rx ready state low");
		rx_en = 1'b0;
		repeat (5) tick();
		chk(rx_pwr === 1'b0 && rxs === 1'b0 && rx_rs === 1'b0, "rx still awake");
		seen = 1'b0;
		repeat (20) begin
			tick();
			seen |= (rx_valid !== 1'b0);
		end
		chk(!seen, "sample while asleep");
	endtask : t_rx
	initial begin
		repeat (16) @(posedge clk);
		chk({tx_pwr, rx_pwr, iload, qload, xfer, rxs, rx_valid} === 7'h00, "reset levels");
		#1 rst_n = 1'b1;
		repeat (3) tick();
		t_fill_drain();
		t_repower();
		t_rx();
		end_sim();
	end
endmodule : tb_iqc_host
